/* File: dv/pcc_pin_src.sv */
// Outside driver for the capture pins of the channel array.
// Assumes the bench resolves each pin against the design's enable.
`timescale 1ns/1ps
`default_nettype none
module pcc_pin_src
  import pcc_pkg::*;
(
  input  wire logic                    clk_i,
  output logic [NUM_CHANNELS-1:0]      pin_o
);
  // Lines rest low until a level is asked for
  initial pin_o = '0;
  // Level changes after a falling edge, then stays for n cycles
  task automatic drive(input int ch, input logic lvl, input int n);
    @(negedge clk_i);
    pin_o[ch] = lvl;
    repeat (n) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: dv/pcc_top_sva.sv */
// Port-level assertions for the capture/compare channel array.
// Assumes one clock domain and the mirror latencies of the top.
`timescale 1ns/1ps
`default_nettype none
module pcc_top_sva
  import pcc_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS
)
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire pcc_wr_t                 wr_i,
  input  wire logic [NCH-1:0]          flag_clr_i,
  input  wire logic [NCH-1:0]          channel_pin_o,
  input  wire logic [NCH-1:0]          channel_event_flag_o,
  input  wire logic [NCH-1:0]          channel_irq_o,
  input  wire logic                    counter_overflow_flag_o,
  input  wire logic [CNT_W-1:0]        counter_o,
  input  wire pcc_chan_regs_t [NCH-1:0] chan_regs_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [NCH-1:0] ien;
  logic [7:0]     m1;
  logic [15:0]    w1;
  // Channel 1 carries the compare checks; enables feed the request check
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      ien[i] = chan_regs_o[i].mode[MODE_IRQ_EN];
  end
  assign m1 = chan_regs_o[1].mode;
  assign w1 = {chan_regs_o[1].high, chan_regs_o[1].low};
  // Request port runs one cycle ahead of the flag mirror
  property p_irq;
    ce_i |=> (channel_event_flag_o & $past(ien)) == $past(channel_irq_o);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_hold;
    ($past(channel_event_flag_o) & ~channel_event_flag_o & ~$past(flag_clr_i)
      & ~$past(flag_clr_i, 2)) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_low;
    ce_i && wr_i.wr && wr_i.chan == 3'h1 && wr_i.sel == PCC_REG_LOW
      |-> ##2 !m1[MODE_CMP_EN];
  endproperty
  a_low: assert property (p_low) else $error("low write");
  property p_high;
    ce_i && wr_i.wr && wr_i.chan == 3'h1 && wr_i.sel == PCC_REG_HIGH
      |-> ##2 m1[MODE_CMP_EN];
  endproperty
  a_high: assert property (p_high) else $error("high write");
  property p_ovf;
    $past(counter_o) == CNT_MAX && counter_o == CNT_RESET
      |-> ##[0:2] counter_overflow_flag_o;
  endproperty
  a_ovf: assert property (p_ovf) else $error("no overflow");
  property p_tog;
    $changed(channel_pin_o[1]) && m1[MODE_TOGGLE] && !m1[MODE_PWM]
      |-> ##[0:1] counter_o == w1;
  endproperty
  a_tog: assert property (p_tog) else $error("stray toggle");
  property p_tmr;
    $rose(channel_event_flag_o[1]) && m1[MODE_MATCH] && !m1[MODE_PWM]
      |-> ($past(counter_o) == w1 || counter_o == w1);
  endproperty
  a_tmr: assert property (p_tmr) else $error("stray match");
  property p_off;
    (chan_regs_o[3].mode[MODE_PWM] && !chan_regs_o[3].mode[MODE_TOGGLE]
      && !chan_regs_o[3].mode[MODE_CMP_EN]) [*3] |-> !channel_pin_o[3];
  endproperty
  a_off: assert property (p_off) else $error("pwm not off");
  c_ovf: cover property ($rose(counter_overflow_flag_o));
  c_irq: cover property ($rose(channel_irq_o[1]));
  c_cap: cover property ($rose(channel_event_flag_o[0]));
endmodule
bind pcc_top pcc_top_sva #(.NCH(NCH)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wr_i(wr_i), .flag_clr_i(flag_clr_i),
  .channel_pin_o(channel_pin_o), .channel_irq_o(channel_irq_o),
  .channel_event_flag_o(channel_event_flag_o), .counter_o(counter_o),
  .counter_overflow_flag_o(counter_overflow_flag_o),
  .chan_regs_o(chan_regs_o));
`default_nettype wire

/* File: dv/pcc_top_test.sv */
// Self-checking bench for the capture/compare channel array.
// Assumes the top, its checker and the pin source are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pcc_top_test;
  import pcc_pkg::*;
  typedef struct {logic [2:0] c; pcc_reg_t s; logic [7:0] d, m, l, h;} row_t;
  logic clk_i, rst_i, ce_i, tick_i, counter_run_i, ovf_clr_i;
  logic counter_overflow_flag_o;
  pcc_wr_t wr_i;
  logic [4:0] flag_clr_i, channel_pin_i, channel_pin_o, channel_pin_oe_n_o;
  logic [4:0] channel_event_flag_o, channel_irq_o, src;
  logic [15:0] counter_o, v;
  pcc_chan_regs_t [4:0] chan_regs_o;
  int miscompares = 0, checked = 0, cyc = 0, hi[5], ed[5];
  // Writes set up channels 0..4; a write to channel 5 must be ignored
  // Channel 4 enables match interrupts to pace duty updates
  row_t rows[13] = '{
    '{1, PCC_REG_LOW,  8'h00, 8'h00, 8'h00, 8'h00},
    '{1, PCC_REG_HIGH, 8'h01, 8'h40, 8'h00, 8'h01},
    '{1, PCC_REG_MODE, 8'h4D, 8'h4D, 8'h00, 8'h01},
    '{2, PCC_REG_HIGH, 8'h00, 8'h40, 8'h00, 8'h00},
    '{2, PCC_REG_MODE, 8'h4E, 8'h4E, 8'h00, 8'h00},
    '{3, PCC_REG_LOW,  8'h40, 8'h00, 8'h40, 8'h00},
    '{3, PCC_REG_HIGH, 8'h40, 8'h40, 8'h40, 8'h40},
    '{3, PCC_REG_MODE, 8'h42, 8'h42, 8'h40, 8'h40},
    '{4, PCC_REG_MODE, 8'hCB, 8'hCB, 8'h00, 8'h00},
    '{4, PCC_REG_LOW,  8'h00, 8'h8B, 8'h00, 8'h00},
    '{4, PCC_REG_HIGH, 8'hC0, 8'hCB, 8'h00, 8'hC0},
    '{5, PCC_REG_MODE, 8'hFF, 8'hCB, 8'h00, 8'hC0},
    '{0, PCC_REG_MODE, 8'h11, 8'h11, 8'h00, 8'h00}};
  // Pin wire: the design wins while it drives, else the outside source
  assign channel_pin_i = (~channel_pin_oe_n_o & channel_pin_o)
                       | (channel_pin_oe_n_o & src);
  pcc_top u_dut (.clk_i, .rst_i, .ce_i, .tick_i, .counter_run_i, .wr_i,
    .flag_clr_i, .ovf_clr_i, .channel_pin_i, .channel_pin_o,
    .channel_pin_oe_n_o, .channel_event_flag_o, .channel_irq_o,
    .counter_overflow_flag_o, .counter_o, .chan_regs_o);
  pcc_pin_src u_src (.clk_i(clk_i), .pin_o(src));
  task automatic cmp(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [2:0] c, input pcc_reg_t s, logic [7:0] d);
    @(negedge clk_i);
    wr_i = '{1'b1, c, s, d};
    @(negedge clk_i);
    wr_i.wr = 1'b0;
  endtask
  // High cycles and edges per pin; windows of whole periods need no phase
  task automatic measure(input int n);
    logic [4:0] last;
    last = channel_pin_o;
    hi = '{default: 0};
    ed = '{default: 0};
    repeat (n)
    begin
      @(negedge clk_i);
      for (int i = 0; i < 5; i++)
      begin
        hi[i] += int'(channel_pin_o[i]);
        ed[i] += int'(channel_pin_o[i] != last[i]);
      end
      last = channel_pin_o;
    end
  endtask
  task automatic pulse_clr(input logic [4:0] f, input logic o);
    @(negedge clk_i);
    flag_clr_i = f;
    ovf_clr_i = o;
    @(negedge clk_i);
    flag_clr_i = '0;
    ovf_clr_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic wrap_up();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Cycle ceiling: the long run needs about 67000 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  initial
  begin
    {rst_i, ce_i, tick_i, counter_run_i} = 4'b1110;
    {wr_i, flag_clr_i, ovf_clr_i} = '0;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    cmp("oe_n", 5'h1F, channel_pin_oe_n_o);
    cmp("regs1", 24'h0, chan_regs_o[1]);
    foreach (rows[r])
    begin
      wreg(rows[r].c, rows[r].s, rows[r].d);
      repeat (2) @(negedge clk_i);
      v = (rows[r].c > 4) ? 16'h4 : 16'(rows[r].c);
      cmp("regs", {rows[r].m, rows[r].l, rows[r].h}, chan_regs_o[v]);
    end
    // Capture on channel 0, falling edge only, with the counter parked
    counter_run_i = 1'b1;
    repeat (37) @(negedge clk_i);
    counter_run_i = 1'b0;
    repeat (3) @(negedge clk_i);
    v = counter_o;
    u_src.drive(0, 1'b1, 3);
    repeat (4) @(negedge clk_i);
    cmp("rise flag", 1'b0, channel_event_flag_o[0]);
    u_src.drive(0, 1'b0, 3);
    repeat (4) @(negedge clk_i);
    cmp("cap flag", 1'b1, channel_event_flag_o[0]);
    cmp("cap irq", 1'b1, channel_irq_o[0]);
    cmp("cap word", v, {chan_regs_o[0].high, chan_regs_o[0].low});
    pulse_clr(5'h01, 1'b0);
    cmp("cleared", 5'h00, channel_event_flag_o);
    // One full counter period with all output modes running
    counter_run_i = 1'b1;
    repeat (300) @(negedge clk_i);
    measure(65536);
    cmp("pwm16 high", 16384, hi[4]);
    cmp("pwm8 high", 49152, hi[3]);
    cmp("freq edges", 256, ed[2]);
    cmp("hso edges", 1, ed[1]);
    cmp("flags", 5'h16, channel_event_flag_o);
    cmp("irq", 5'h12, channel_irq_o);
    cmp("ovf", 1'b1, counter_overflow_flag_o);
    pulse_clr(5'h16, 1'b1);
    cmp("ovf clr", 1'b0, counter_overflow_flag_o);
    cmp("irq clr", 5'h00, channel_irq_o);
    // Low byte writes switch the channel 1..3 comparators off; channel 1 word lands
    // inside the window so a stray toggle would show
    wreg(1, PCC_REG_LOW, 8'hC0);
    wreg(2, PCC_REG_LOW, 8'h00);
    wreg(3, PCC_REG_LOW, 8'h40);
    repeat (4) @(negedge clk_i);
    measure(600);
    cmp("pwm8 off", 0, hi[3]);
    cmp("freq off", 0, ed[2]);
    cmp("hso off", 0, ed[1]);
    // Clock enable low freezes the running counter
    ce_i = 1'b0;
    v = counter_o;
    repeat (5) @(negedge clk_i);
    cmp("ce hold", v, counter_o);
    ce_i = 1'b1;
    // Reset in mid-run returns every output to its idle value
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    cmp("rst count", 16'h0, counter_o);
    cmp("rst pins", 5'h00, channel_pin_o);
    cmp("rst oe_n", 5'h1F, channel_pin_oe_n_o);
    cmp("rst regs", 24'h0, chan_regs_o[4]);
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: include/pcc_pkg.sv */
// Constants and types for the counter array capture/compare channels.
// Assumes a single system clock; the counter tick comes from outside.
//
// Overview of operation
// - Mode bits: 7 wide PWM, 6 comparator, 5/4 edges, 3 match, 2 toggle, 1 PWM, 0 irq
// - Capture mode copies the 16-bit counter into both compare bytes on chosen edge
// - Each capture sets the event flag, which stays until software clears it
// - Interrupt request when event flag and channel interrupt enable are both set
// - Software timer: counter equals compare word sets the event flag
// - Low byte write clears comparator enable; high byte write sets it
// - High-speed output toggles pin and sets flag on each 16-bit match
// - High-speed output with comparator off holds the pin level
// - Frequency output toggles on low-byte match, then adds high byte to low byte
// - Frequency high byte zero means 256 counts between toggles
// - Frequency mode with match bit sets flag on full 16-bit equality
// - 8-bit PWM: pin high on low-byte match, low on low-byte overflow
// - 8-bit PWM reloads low byte from high byte at each low-byte rollover
// - 8-bit PWM selected with bit 7 clear; match bit flags each 8-bit match
// - 8-bit PWM high time is 256 minus high byte out of 256
// - 16-bit PWM: pin high on 16-bit match, low on counter overflow
// - 16-bit PWM with match bit sets event flag on every 16-bit match
// - 16-bit PWM high time is 65536 minus compare word out of 65536
// - Comparator off: toggle modes hold the pin, PWM modes output zero
// - Counter wrap from 0xFFFF to zero sets the counter overflow flag
// - Five channels, each with own pin and compare word, share one counter
package pcc_pkg;

  localparam int          NUM_CHANNELS    = 5;
  localparam int          CNT_W           = 16;
  // Mode register field positions
  localparam int          MODE_WIDE_PWM   = 7;
  localparam int          MODE_CMP_EN     = 6;
  localparam int          MODE_CAP_RISE   = 5;
  localparam int          MODE_CAP_FALL   = 4;
  localparam int          MODE_MATCH      = 3;
  localparam int          MODE_TOGGLE     = 2;
  localparam int          MODE_PWM        = 1;
  localparam int          MODE_IRQ_EN     = 0;
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [7:0]  CMP_BYTE_RESET  = 8'h00;
  localparam logic [15:0] CNT_RESET       = 16'h0000;
  localparam logic [15:0] CNT_MAX         = 16'hFFFF;
  localparam logic [7:0]  LOW_MAX         = 8'hFF;

  // Register select codes on the channel register port
  typedef enum logic [1:0] {
    PCC_REG_MODE = 2'h0,
    PCC_REG_LOW  = 2'h1,
    PCC_REG_HIGH = 2'h2
  } pcc_reg_t;

  // Processor register access
  typedef struct packed {
    logic       wr;
    logic [2:0] chan;
    pcc_reg_t   sel;
    logic [7:0] data;
  } pcc_wr_t;

  // Per-channel state as seen by the processor
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] low;
    logic [7:0] high;
  } pcc_chan_regs_t;

endpackage

/* File: rtl/pcc_sync.sv */
// Two-stage synchroniser bank for the capture pins.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module pcc_sync
#(
  parameter int WIDTH = 5
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage1 <= '0;
      sync_o <= '0;
    end
    else if (ce_i)
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/pcc_top.sv */
// Counter array: shared 16-bit counter and five capture/compare channels.
// Assumes the counter tick is a one-cycle pulse from a timebase outside.
`timescale 1ns/1ps
`default_nettype none
module pcc_top
  import pcc_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS
)
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire logic                  tick_i,
  input  wire logic                  counter_run_i,
  input  wire pcc_wr_t               wr_i,
  input  wire logic [NCH-1:0]        flag_clr_i,
  input  wire logic                  ovf_clr_i,
  input  wire logic [NCH-1:0]        channel_pin_i,
  output logic      [NCH-1:0]        channel_pin_o,
  output logic      [NCH-1:0]        channel_pin_oe_n_o,
  output logic      [NCH-1:0]        channel_event_flag_o,
  output logic      [NCH-1:0]        channel_irq_o,
  output logic                       counter_overflow_flag_o,
  output logic      [CNT_W-1:0]      counter_o,
  output pcc_chan_regs_t [NCH-1:0]   chan_regs_o
);

  // Mode helpers used for every channel
  function automatic logic is_capture(input logic [7:0] m);
    is_capture = (m[MODE_CAP_RISE] | m[MODE_CAP_FALL])
                 & ~m[MODE_MATCH] & ~m[MODE_TOGGLE] & ~m[MODE_PWM];
  endfunction

  function automatic logic is_timer(input logic [7:0] m);
    is_timer = m[MODE_MATCH] & ~m[MODE_TOGGLE] & ~m[MODE_PWM];
  endfunction

  function automatic logic is_hso(input logic [7:0] m);
    is_hso = m[MODE_MATCH] & m[MODE_TOGGLE] & ~m[MODE_PWM];
  endfunction

  function automatic logic is_freq(input logic [7:0] m);
    is_freq = m[MODE_TOGGLE] & m[MODE_PWM];
  endfunction

  function automatic logic is_pwm8(input logic [7:0] m);
    is_pwm8 = m[MODE_PWM] & ~m[MODE_TOGGLE]
              & ~m[MODE_WIDE_PWM];
  endfunction

  function automatic logic is_pwm16(input logic [7:0] m);
    is_pwm16 = m[MODE_PWM] & ~m[MODE_TOGGLE]
               & m[MODE_WIDE_PWM];
  endfunction

  logic [CNT_W-1:0] count;
  logic [NCH-1:0]   pin_sync;
  logic [NCH-1:0]   pin_prev;
  logic [7:0]       mode [NCH];
  logic [7:0]       cmp_low [NCH];
  logic [7:0]       cmp_high [NCH];
  logic [NCH-1:0]   pin_out;
  logic [NCH-1:0]   flag;
  logic             ovf_flag;
  logic             step;
  logic             wrap16;
  logic             wrap8;

  // Counter advances only on a timebase tick while running
  assign step   = tick_i & counter_run_i;
  assign wrap16 = step & (count == CNT_MAX);
  assign wrap8  = step & (count[7:0] == LOW_MAX);

  pcc_sync #(
    .WIDTH (NCH)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i (channel_pin_i),
    .sync_o  (pin_sync)
  );

  // Shared counter, one for all channels
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count <= CNT_RESET;
    else if (ce_i && step)
      count <= count + 16'h0001;
  end

  // Overflow flag: a wrap in the clearing cycle wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ovf_flag <= 1'b0;
    else if (ce_i)
    begin
      if (wrap16)
        ovf_flag <= 1'b1;
      else if (ovf_clr_i)
        ovf_flag <= 1'b0;
    end
  end

  // Previous synchronised level for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_prev <= '0;
    else if (ce_i)
      pin_prev <= pin_sync;
  end

  // Per-channel logic
  for (genvar n = 0; n < NCH; n++)
  begin : g_chan
    logic       rise;
    logic       fall;
    logic       cap;
    logic       match16;
    logic       match8;
    logic       wr_mode;
    logic       wr_low;
    logic       wr_high;
    logic       flag_set;
    logic [7:0] m;

    assign m       = mode[n];
    assign rise    = pin_sync[n] & ~pin_prev[n];
    assign fall    = ~pin_sync[n] & pin_prev[n];
    // Capture samples the counter value held in this cycle
    assign cap     = is_capture(m)
                     & ((m[MODE_CAP_RISE] & rise)
                      | (m[MODE_CAP_FALL] & fall));
    // Matches act once, on the tick that reaches the compare value
    assign match16 = step & m[MODE_CMP_EN]
                     & (count + 16'h0001 == {cmp_high[n], cmp_low[n]});
    assign match8  = step & m[MODE_CMP_EN]
                     & (count[7:0] + 8'h01 == cmp_low[n]);
    assign wr_mode = wr_i.wr & (wr_i.chan == 3'(n))
                     & (wr_i.sel == PCC_REG_MODE);
    assign wr_low  = wr_i.wr & (wr_i.chan == 3'(n))
                     & (wr_i.sel == PCC_REG_LOW);
    assign wr_high = wr_i.wr & (wr_i.chan == 3'(n))
                     & (wr_i.sel == PCC_REG_HIGH);

    // Event sources for the flag
    assign flag_set = cap
                    | (match16 & is_timer(m))
                    | (match16 & is_hso(m))
                    | (match16 & is_freq(m) & m[MODE_MATCH])
                    | (match8 & is_pwm8(m) & m[MODE_MATCH])
                    | (match16 & is_pwm16(m) & m[MODE_MATCH]);

    // Mode register; compare byte writes steer the comparator bit
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        mode[n] <= MODE_RESET;
      else if (ce_i)
      begin
        if (wr_mode)
          mode[n] <= wr_i.data;
        else if (wr_low)
          mode[n][MODE_CMP_EN] <= 1'b0;
        else if (wr_high)
          mode[n][MODE_CMP_EN] <= 1'b1;
      end
    end

    // Compare bytes: capture, write, frequency step, PWM reload
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        cmp_low[n]  <= CMP_BYTE_RESET;
        cmp_high[n] <= CMP_BYTE_RESET;
      end
      else if (ce_i)
      begin
        if (cap)
        begin
          cmp_low[n]  <= count[7:0];
          cmp_high[n] <= count[15:8];
        end
        else
        begin
          if (wr_low)
            cmp_low[n] <= wr_i.data;
          else if (is_freq(m) && match8)
            // High byte zero wraps the sum to a full 256 step
            cmp_low[n] <= cmp_low[n] + cmp_high[n];
          else if (is_pwm8(m) && wrap8)
            cmp_low[n] <= cmp_high[n];
          if (wr_high)
            cmp_high[n] <= wr_i.data;
        end
      end
    end

    // Output pin behaviour per mode
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        pin_out[n] <= 1'b0;
      else if (ce_i)
      begin
        if ((is_pwm8(m) || is_pwm16(m)) && !m[MODE_CMP_EN])
          pin_out[n] <= 1'b0;
        else if (is_hso(m) && match16)
          pin_out[n] <= ~pin_out[n];
        else if (is_freq(m) && match8)
          pin_out[n] <= ~pin_out[n];
        else if (is_pwm8(m))
        begin
          // Match and wrap together: wrap wins, giving 256-high duty
          if (wrap8)
            pin_out[n] <= (cmp_high[n] == 8'h00);
          else if (match8)
            pin_out[n] <= 1'b1;
        end
        else if (is_pwm16(m))
        begin
          if (wrap16)
            pin_out[n] <= ({cmp_high[n], cmp_low[n]} == CNT_RESET);
          else if (match16)
            pin_out[n] <= 1'b1;
        end
      end
    end

    // Event flag: hardware set beats a software clear
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        flag[n] <= 1'b0;
      else if (ce_i)
      begin
        if (flag_set)
          flag[n] <= 1'b1;
        else if (flag_clr_i[n])
          flag[n] <= 1'b0;
      end
    end

    // Registered copies for the outputs
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        channel_pin_o[n]        <= 1'b0;
        channel_pin_oe_n_o[n]   <= 1'b1;
        channel_irq_o[n]        <= 1'b0;
        chan_regs_o[n]          <= '0;
      end
      else if (ce_i)
      begin
        channel_pin_o[n]      <= pin_out[n];
        // Pin is an input in capture mode and when no mode is set
        channel_pin_oe_n_o[n] <= ~(m[MODE_TOGGLE] | m[MODE_PWM]);
        channel_irq_o[n]      <= (flag_set | (flag[n] & ~flag_clr_i[n]))
                                 & m[MODE_IRQ_EN];
        chan_regs_o[n]        <= '{mode: m, low: cmp_low[n],
                                   high: cmp_high[n]};
      end
    end
  end

  // Flag and counter mirrors, all from flip-flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      channel_event_flag_o    <= '0;
      counter_overflow_flag_o <= 1'b0;
      counter_o               <= CNT_RESET;
    end
    else if (ce_i)
    begin
      channel_event_flag_o    <= flag;
      counter_overflow_flag_o <= ovf_flag;
      counter_o               <= count;
    end
  end

endmodule
`default_nettype wire
